// >>> core/txcfg_pkg.sv
// Constants and carrier types of the transmit configuration bank
//
// Behaviour
// - Power-down set turns the transmitter off.
// - Response clear: limit current while over-current lasts.
// - Response set: limit for 1 ms, then float tip and ring.
// - Single-ended clear drives tip and ring; set tip only.
// - Termination code picks transformer, bare or external matching.
// - Multifunction select acts only in formats 10 and 00.
// - Codes 000..100: pattern, alarm, over-current, tx loss, zeros.
// - Codes 101..111 act in dual-rail RZ only.
// - Edge select 0 samples on falling edge, 1 on rising.
// - Polarity 1 makes data and rails active low.
// - Line code 0 gives B8ZS or HDB3, 1 gives AMI.
// - Format 00: single-rail NRZ on the data pin.
// - Format 01: dual-rail NRZ on the rails.
// - Format 10: dual-rail RZ; code 11 reserved.
// - Interface register is read/write, resets to 01H.
// - Output enable 0 floats tip and ring.
package txcfg_pkg;

    localparam int NUM_CH = 4;

    // Byte address is four times the index
    localparam logic [10:0] IDX_LINE_DRIVER_CFG = 11'h004;
    localparam logic [10:0] IDX_INTERFACE_CFG = 11'h005;
    localparam logic [10:0] IDX_CH_STRIDE = 11'h040;
    localparam logic [10:0] IDX_IRQ_STATUS = 11'h7F0;
    localparam logic [10:0] IDX_IRQ_MASK = 11'h7F1;
    localparam int ADDR_W = 13;

    localparam logic [7:0] LINE_DRIVER_CFG_RESET = 8'h00;
    localparam logic [7:0] INTERFACE_CFG_RESET = 8'h01;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

    // Line driver register fields
    localparam int LD_OE_BIT = 6;
    localparam int LD_OFF_BIT = 5;
    localparam int LD_OCHIZ_BIT = 4;
    localparam int LD_SING_BIT = 3;
    localparam int LD_TERM_LSB = 0;

    // Interface register fields
    localparam int IF_MF_LSB = 5;
    localparam int IF_EDGE_BIT = 4;
    localparam int IF_POL_BIT = 3;
    localparam int IF_CODE_BIT = 2;
    localparam int IF_FMT_LSB = 0;

    // Status: over-current onset at n, trip at n + NUM_CH
    localparam int ST_TRIP_LSB = NUM_CH;

    // Grace time before the outputs float
    localparam int OC_HIZ_TIME_US = 1000;
    localparam int CLK_MHZ = 250;
    localparam int OC_HIZ_CYCLES_DFLT = OC_HIZ_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        FMT_SINGLE_NRZ = 2'b00,
        FMT_DUAL_NRZ = 2'b01,
        FMT_DUAL_RZ = 2'b10,
        FMT_RESERVED = 2'b11
    } tx_interface_format_e;

    typedef enum logic [2:0] {
        MF_PATTERN = 3'b000,
        MF_ALARM = 3'b001,
        MF_OVERCURRENT = 3'b010,
        MF_TX_LOSS = 3'b011,
        MF_EXCESS_ZEROS = 3'b100,
        MF_BIPOLAR_VIOL = 3'b101,
        MF_ZEROS_OR_VIOL = 3'b110,
        MF_SIGNAL_LOSS = 3'b111
    } multifunction_pin_select_e;

    typedef struct packed {
        logic line_output_enable;
        logic tx_power_down;
        logic overcurrent_hiz_select;
        logic single_ended_tx_select;
        logic [2:0] termination_select;
        multifunction_pin_select_e multifunction_pin_select;
        logic tx_clock_edge_select;
        logic tx_data_polarity;
        logic line_code_ami;
        tx_interface_format_e tx_interface_format;
    } chan_cfg_s;

    typedef struct packed {
        logic arbitrary_pattern_detect;
        logic pattern_on_tx_path;
        logic alarm_indication_flag;
        logic tx_signal_loss_flag;
        logic excess_zeros_flag;
        logic bipolar_violation_flag;
        logic signal_loss_flag;
    } indications_s;

endpackage

// >>> core/tx_link_sampler.sv
// Transmit clock edge finder and rail capture, one channel
`timescale 1ns/10ps
module tx_link_sampler
    import txcfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_clock_pin,
    input wire logic tx_data_pin,
    input wire logic tx_pos_rail_pin,
    input wire logic tx_neg_rail_pin,
    input wire logic clock_edge_sel,
    input wire logic data_polarity,
    input wire tx_interface_format_e fmt,
    output logic pos_q,
    output logic neg_q,
    output logic strobe_q
);

    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic clk_last_q;
    logic active_edge;
    logic pos_raw;
    logic neg_raw;

    // Two flops per pin; logic reads only sync_q
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end else begin
            meta_q <= {tx_clock_pin, tx_data_pin, tx_pos_rail_pin, tx_neg_rail_pin};
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_last_q <= 1'b0;
        end else begin
            clk_last_q <= sync_q[3];
        end
    end

    // Falling edge unless rising is selected
    assign active_edge = clock_edge_sel ? (sync_q[3] & ~clk_last_q)
                                        : (~sync_q[3] & clk_last_q);

    always_comb begin
        pos_raw = sync_q[1] ^ data_polarity;
        neg_raw = sync_q[0] ^ data_polarity;
        if (fmt == FMT_SINGLE_NRZ) begin
            pos_raw = sync_q[2] ^ data_polarity;
            neg_raw = 1'b0;
        end
    end

    // Reserved format captures nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_q <= 1'b0;
            neg_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= active_edge && (fmt != FMT_RESERVED);
            if (active_edge && (fmt != FMT_RESERVED)) begin
                pos_q <= pos_raw;
                neg_q <= neg_raw;
            end
        end
    end

endmodule

// >>> core/tx_path_config.sv
// Transmit configuration bank with APB and interrupt
`timescale 1ns/10ps
module tx_path_config
    import txcfg_pkg::*;
#(
    parameter int OC_HIZ_CYCLES = OC_HIZ_CYCLES_DFLT
)(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire logic [NUM_CH-1:0] TX_CLOCK_PIN,
    input wire logic [NUM_CH-1:0] TX_DATA_PIN,
    input wire logic [NUM_CH-1:0] TX_POS_RAIL_PIN,
    input wire logic [NUM_CH-1:0] TX_NEG_RAIL_PIN,
    input wire logic [NUM_CH-1:0] TX_OVERCURRENT_EVENT,
    input wire indications_s [NUM_CH-1:0] INDICATIONS,
    output logic [NUM_CH-1:0] TX_POS_DATA,
    output logic [NUM_CH-1:0] TX_NEG_DATA,
    output logic [NUM_CH-1:0] TX_DATA_STROBE,
    output logic [NUM_CH-1:0] TX_RZ_FORMAT,
    output logic [NUM_CH-1:0] LINE_CODE_AMI,
    output logic [NUM_CH-1:0] TX_POWER_DOWN,
    output logic [NUM_CH-1:0] CURRENT_LIMIT,
    output logic [NUM_CH*3-1:0] TERMINATION_SELECT,
    output logic [NUM_CH-1:0] TERM_TRANSFORMERLESS,
    output logic [NUM_CH-1:0] TERM_EXTERNAL,
    output logic [NUM_CH-1:0] LINE_TIP_OUT,
    output logic [NUM_CH-1:0] LINE_TIP_OE,
    output logic [NUM_CH-1:0] LINE_RING_OUT,
    output logic [NUM_CH-1:0] LINE_RING_OE,
    output logic [NUM_CH-1:0] MULTIFUNCTION_OUT_PIN
);

    localparam int OC_CNT_W = $clog2(OC_HIZ_CYCLES + 1);
    localparam logic [OC_CNT_W-1:0] OC_LIMIT = OC_CNT_W'(OC_HIZ_CYCLES);
    localparam int ST_W = 2 * NUM_CH;

    logic [7:0] line_cfg_q [NUM_CH];
    logic [7:0] if_cfg_q [NUM_CH];
    logic [ST_W-1:0] irq_status_q;
    logic [ST_W-1:0] irq_mask_q;
    logic [ST_W-1:0] irq_set;
    logic [31:0] prdata_q;
    chan_cfg_s cfg [NUM_CH];

    logic access;
    logic wr_en;
    logic rd_en;
    logic [10:0] idx;
    logic [5:0] reg_sel;
    logic [4:0] ch_sel;
    logic ch_hit;
    logic is_line_reg;
    logic is_if_reg;
    logic is_status;
    logic is_mask;
    logic mapped;

    // Splits a register index into its channel number
    function automatic logic [4:0] chan_of(input logic [10:0] index);
        chan_of = index[10:6];
    endfunction

    // Splits a register index into its place within a channel block
    function automatic logic [5:0] slot_of(input logic [10:0] index);
        slot_of = index[5:0];
    endfunction

    // Zero-wait slave: each access ends in one cycle
    assign idx = PADDR[ADDR_W-1:2];
    assign ch_sel = chan_of(idx);
    assign reg_sel = slot_of(idx);
    assign ch_hit = (ch_sel < 5'(NUM_CH));
    assign is_line_reg = ch_hit && (reg_sel == slot_of(IDX_LINE_DRIVER_CFG));
    assign is_if_reg = ch_hit && (reg_sel == slot_of(IDX_INTERFACE_CFG));
    assign is_status = (idx == IDX_IRQ_STATUS);
    assign is_mask = (idx == IDX_IRQ_MASK);
    assign mapped = is_line_reg || is_if_reg || is_status || is_mask;
    assign access = PSEL && PENABLE;
    assign wr_en = access && PWRITE && mapped;
    assign rd_en = access && !PWRITE && mapped;

    assign PREADY = 1'b1;
    assign PSLVERR = access && !mapped;
    assign PRDATA = prdata_q;

    // One set per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_cfg
            always_ff @(posedge CORE_CLK) begin
                if (!RESETN) begin
                    line_cfg_q[g] <= LINE_DRIVER_CFG_RESET;
                end else if (wr_en && is_line_reg && ch_sel == 5'(g)) begin
                    // Bit 7 is reserved
                    line_cfg_q[g] <= {1'b0, PWDATA[6:0]};
                end
            end

            always_ff @(posedge CORE_CLK) begin
                if (!RESETN) begin
                    if_cfg_q[g] <= INTERFACE_CFG_RESET;
                end else if (wr_en && is_if_reg && ch_sel == 5'(g)) begin
                    if_cfg_q[g][7:2] <= PWDATA[7:2];
                    // Code 11 is refused; old format stays
                    if (PWDATA[1:0] != FMT_RESERVED) begin
                        if_cfg_q[g][1:0] <= PWDATA[1:0];
                    end
                end
            end

            always_comb begin
                cfg[g].line_output_enable = line_cfg_q[g][LD_OE_BIT];
                cfg[g].tx_power_down = line_cfg_q[g][LD_OFF_BIT];
                cfg[g].overcurrent_hiz_select = line_cfg_q[g][LD_OCHIZ_BIT];
                cfg[g].single_ended_tx_select = line_cfg_q[g][LD_SING_BIT];
                cfg[g].termination_select = line_cfg_q[g][LD_TERM_LSB +: 3];
                cfg[g].multifunction_pin_select =
                    multifunction_pin_select_e'(if_cfg_q[g][IF_MF_LSB +: 3]);
                cfg[g].tx_clock_edge_select = if_cfg_q[g][IF_EDGE_BIT];
                cfg[g].tx_data_polarity = if_cfg_q[g][IF_POL_BIT];
                cfg[g].line_code_ami = if_cfg_q[g][IF_CODE_BIT];
                cfg[g].tx_interface_format =
                    tx_interface_format_e'(if_cfg_q[g][IF_FMT_LSB +: 2]);
            end
        end
    endgenerate

    // Read data is loaded at setup
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            prdata_q <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            prdata_q <= 32'h0000_0000;
            if (is_line_reg) begin
                prdata_q <= {24'h00_0000, line_cfg_q[ch_sel[1:0]]};
            end else if (is_if_reg) begin
                prdata_q <= {24'h00_0000, if_cfg_q[ch_sel[1:0]]};
            end else if (is_status) begin
                prdata_q <= {{(32 - ST_W){1'b0}}, irq_status_q | irq_set};
            end else if (is_mask) begin
                prdata_q <= {{(32 - ST_W){1'b0}}, irq_mask_q};
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            irq_mask_q <= ST_W'(IRQ_MASK_RESET);
        end else if (wr_en && is_mask) begin
            irq_mask_q <= PWDATA[ST_W-1:0];
        end
    end

    // Read clears; a same-cycle event still lands
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            irq_status_q <= '0;
        end else if (rd_en && is_status) begin
            irq_status_q <= irq_set;
        end else begin
            irq_status_q <= irq_status_q | irq_set;
        end
    end

    assign IRQ = |(irq_status_q & irq_mask_q);

    // Per-channel datapath
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic oc_meta_q;
            logic oc_sync_q;
            logic oc_last_q;
            logic [OC_CNT_W-1:0] oc_cnt_q;
            logic oc_trip_q;
            logic oc_trip_last_q;
            logic pos_s;
            logic neg_s;
            logic strobe_s;
            logic drive_en;
            logic mf_d;
            logic mf_q;
            logic tip_q;
            logic ring_q;
            logic tip_oe_q;
            logic ring_oe_q;
            indications_s ind;

            assign ind = INDICATIONS[g];

            tx_link_sampler u_sampler (
                .clk(CORE_CLK),
                .rst_n(RESETN),
                .tx_clock_pin(TX_CLOCK_PIN[g]),
                .tx_data_pin(TX_DATA_PIN[g]),
                .tx_pos_rail_pin(TX_POS_RAIL_PIN[g]),
                .tx_neg_rail_pin(TX_NEG_RAIL_PIN[g]),
                .clock_edge_sel(cfg[g].tx_clock_edge_select),
                .data_polarity(cfg[g].tx_data_polarity),
                .fmt(cfg[g].tx_interface_format),
                .pos_q(pos_s),
                .neg_q(neg_s),
                .strobe_q(strobe_s)
            );

            // Detector is analog, so resynchronised
            always_ff @(posedge CORE_CLK) begin
                if (!RESETN) begin
                    oc_meta_q <= 1'b0;
                    oc_sync_q <= 1'b0;
                    oc_last_q <= 1'b0;
                end else begin
                    oc_meta_q <= TX_OVERCURRENT_EVENT[g];
                    oc_sync_q <= oc_meta_q;
                    oc_last_q <= oc_sync_q;
                end
            end

            // Grace timer; a detector drop releases the outputs
            always_ff @(posedge CORE_CLK) begin
                if (!RESETN) begin
                    oc_cnt_q <= '0;
                    oc_trip_q <= 1'b0;
                end else if (!oc_sync_q || !cfg[g].overcurrent_hiz_select) begin
                    oc_cnt_q <= '0;
                    oc_trip_q <= 1'b0;
                end else if (oc_cnt_q < OC_LIMIT) begin
                    oc_cnt_q <= oc_cnt_q + 1'b1;
                end else begin
                    oc_trip_q <= 1'b1;
                end
            end

            always_ff @(posedge CORE_CLK) begin
                if (!RESETN) begin
                    oc_trip_last_q <= 1'b0;
                end else begin
                    oc_trip_last_q <= oc_trip_q;
                end
            end

            assign irq_set[g] = oc_sync_q && !oc_last_q;
            assign irq_set[ST_TRIP_LSB + g] = oc_trip_q && !oc_trip_last_q;

            // Limit while over-current is seen and not tripped
            assign CURRENT_LIMIT[g] = oc_sync_q && !oc_trip_q;
            assign drive_en = cfg[g].line_output_enable
                              && !cfg[g].tx_power_down
                              && !oc_trip_q;

            always_ff @(posedge CORE_CLK) begin
                if (!RESETN) begin
                    tip_q <= 1'b0;
                    ring_q <= 1'b0;
                    tip_oe_q <= 1'b0;
                    ring_oe_q <= 1'b0;
                end else begin
                    tip_q <= drive_en && pos_s;
                    ring_q <= drive_en && !cfg[g].single_ended_tx_select && neg_s;
                    tip_oe_q <= drive_en;
                    ring_oe_q <= drive_en && !cfg[g].single_ended_tx_select;
                end
            end

            // Reserved combinations give a quiet low
            always_comb begin
                mf_d = 1'b0;
                if (cfg[g].tx_interface_format == FMT_DUAL_RZ
                    || cfg[g].tx_interface_format == FMT_SINGLE_NRZ) begin
                    case (cfg[g].multifunction_pin_select)
                        MF_PATTERN:
                            mf_d = ind.pattern_on_tx_path && ind.arbitrary_pattern_detect;
                        MF_ALARM: mf_d = ind.alarm_indication_flag;
                        MF_OVERCURRENT: mf_d = oc_sync_q;
                        MF_TX_LOSS: mf_d = ind.tx_signal_loss_flag;
                        MF_EXCESS_ZEROS: mf_d = ind.excess_zeros_flag;
                        default: begin
                            if (cfg[g].tx_interface_format == FMT_DUAL_RZ) begin
                                case (cfg[g].multifunction_pin_select)
                                    MF_BIPOLAR_VIOL: mf_d = ind.bipolar_violation_flag;
                                    MF_ZEROS_OR_VIOL:
                                        mf_d = ind.excess_zeros_flag
                                               || ind.bipolar_violation_flag;
                                    default: mf_d = ind.signal_loss_flag;
                                endcase
                            end
                        end
                    endcase
                end
            end

            always_ff @(posedge CORE_CLK) begin
                if (!RESETN) begin
                    mf_q <= 1'b0;
                end else begin
                    mf_q <= mf_d;
                end
            end

            assign MULTIFUNCTION_OUT_PIN[g] = mf_q;
            assign LINE_TIP_OUT[g] = tip_q;
            assign LINE_RING_OUT[g] = ring_q;
            assign LINE_TIP_OE[g] = tip_oe_q;
            assign LINE_RING_OE[g] = ring_oe_q;
            assign TX_POS_DATA[g] = pos_s;
            assign TX_NEG_DATA[g] = neg_s;
            assign TX_DATA_STROBE[g] = strobe_s;
            assign TX_RZ_FORMAT[g] = (cfg[g].tx_interface_format == FMT_DUAL_RZ);
            // Low: encoder picks B8ZS or HDB3 by T1/E1 mode
            assign LINE_CODE_AMI[g] = cfg[g].line_code_ami;
            assign TX_POWER_DOWN[g] = cfg[g].tx_power_down;
            assign TERMINATION_SELECT[g*3 +: 3] = cfg[g].termination_select;
            assign TERM_TRANSFORMERLESS[g] = cfg[g].termination_select[2]
                                             && (cfg[g].termination_select != 3'b111);
            assign TERM_EXTERNAL[g] = (cfg[g].termination_select == 3'b111);
        end
    endgenerate

endmodule

// >>> dv/tx_path_config_properties.sv
// Concurrent checks on the transmit configuration bank ports
`timescale 1ns/10ps
module tx_path_config_properties
    import txcfg_pkg::*;
#(
    parameter int OC_HIZ_CYCLES = 20
)(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [NUM_CH-1:0] TX_OVERCURRENT_EVENT,
    input wire logic [NUM_CH-1:0] TX_DATA_STROBE,
    input wire logic [NUM_CH-1:0] TX_RZ_FORMAT,
    input wire logic [NUM_CH-1:0] LINE_CODE_AMI,
    input wire logic [NUM_CH-1:0] TX_POWER_DOWN,
    input wire logic [NUM_CH-1:0] CURRENT_LIMIT,
    input wire logic [NUM_CH*3-1:0] TERMINATION_SELECT,
    input wire logic [NUM_CH-1:0] TERM_TRANSFORMERLESS,
    input wire logic [NUM_CH-1:0] TERM_EXTERNAL,
    input wire logic [NUM_CH-1:0] LINE_TIP_OE,
    input wire logic [NUM_CH-1:0] LINE_RING_OE
);
    logic [31:0] oc_cnt_q;
    logic wr_if0;
    assign wr_if0 = PSEL && PENABLE && PWRITE && PADDR == 13'h0014;
    // Counted on the raw pin, so a margin covers the synchroniser
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN || !TX_OVERCURRENT_EVENT[0]) begin
            oc_cnt_q <= 32'h0;
        end else begin
            oc_cnt_q <= oc_cnt_q + 32'h1;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    a_power_down_off: assert property (TX_POWER_DOWN[0] && $past(TX_POWER_DOWN[0])
        |-> !LINE_TIP_OE[0]) else $error("tip on in power-down");
    a_limit_window: assert property (oc_cnt_q >= 32'h4 && oc_cnt_q <= OC_HIZ_CYCLES
        |-> CURRENT_LIMIT[0]) else $error("no limit in grace");
    a_limit_idle: assert property (!TX_OVERCURRENT_EVENT[0] [*4] |-> !CURRENT_LIMIT[0])
        else $error("stray limit");
    a_ring_needs_tip: assert property (LINE_RING_OE[0] |-> LINE_TIP_OE[0])
        else $error("ring driven without tip");
    a_term_external: assert property (TERM_EXTERNAL[0] == (TERMINATION_SELECT[2:0] == 3'h7))
        else $error("external decode");
    a_term_bare: assert property (TERM_TRANSFORMERLESS[0] ==
        (TERMINATION_SELECT[2] && TERMINATION_SELECT[1:0] != 2'h3)) else $error("bare decode wrong");
    a_strobe_single: assert property (TX_DATA_STROBE[0] |=> !TX_DATA_STROBE[0])
        else $error("long strobe");
    a_code_write: assert property (wr_if0 |=> LINE_CODE_AMI[0] == $past(PWDATA[2]))
        else $error("line code");
    a_rz_write: assert property (wr_if0 && PWDATA[1:0] != 2'h3
        |=> TX_RZ_FORMAT[0] == ($past(PWDATA[1:0]) == 2'h2)) else $error("rz format wrong");
    c_strobe: cover property (TX_DATA_STROBE[0]);
    c_trip: cover property (TX_OVERCURRENT_EVENT[0] && !CURRENT_LIMIT[0] && oc_cnt_q > 32'h8);
    c_rz: cover property (wr_if0 && PWDATA[1:0] == 2'h2);
endmodule
bind tx_path_config tx_path_config_properties #(.OC_HIZ_CYCLES(OC_HIZ_CYCLES)) u_props (.*);

// >>> dv/framer_model.sv
// Framer model: transmit clock and data lanes
`timescale 1ns/10ps
module framer_model (
    input wire logic run,
    input wire logic edge_rise,
    input wire logic rz,
    input wire logic [7:0] pattern,
    output logic clk_pin,
    output logic data_pin,
    output logic pos_pin,
    output logic neg_pin
);
    initial begin
        clk_pin = 1'b0;
        data_pin = 1'b0;
        pos_pin = 1'b0;
        neg_pin = 1'b1;
        forever begin
            wait (run);
            for (int i = 7; i >= 0; i--) begin
                clk_pin = !edge_rise;
                // Mid-half data change catches a wrong-edge sampler
                #40 data_pin = pattern[i];
                pos_pin = pattern[i];
                neg_pin = !pattern[i];
                #40 clk_pin = edge_rise;
                #40;
                if (rz) begin
                    pos_pin = 1'b0;
                    neg_pin = 1'b0;
                end
                #40;
            end
            // Clock stands; lines leave the last bit
            data_pin = !data_pin;
            pos_pin = !pos_pin;
            neg_pin = !neg_pin;
            wait (!run);
        end
    end
endmodule

// >>> dv/tx_path_config_interface_tb.sv
// Self-checking bench, transmit configuration bank
`timescale 1ns/10ps
module tx_path_config_interface_tb
    import txcfg_pkg::*;
;
    localparam int OCH = 20;
    logic clk, rstn, psel, pen, pwr, pready, pslverr, irq, err;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] oc, pos_o, neg_o, stb, rzf, ami, pdn, clim, tless, text, tipoe, ringoe, mf;
    logic [11:0] term;
    indications_s [3:0] ind;
    logic run, erise, rz, fclk, fdat, fpos, fneg;
    logic [7:0] pat;
    int failures, n_checks, cyc;
    tx_path_config #(.OC_HIZ_CYCLES(OCH)) dut (.CORE_CLK(clk), .RESETN(rstn), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .TX_CLOCK_PIN({4{fclk}}),
        .TX_DATA_PIN({4{fdat}}), .TX_POS_RAIL_PIN({4{fpos}}), .TX_NEG_RAIL_PIN({4{fneg}}),
        .TX_OVERCURRENT_EVENT(oc), .INDICATIONS(ind), .TX_POS_DATA(pos_o), .TX_NEG_DATA(neg_o),
        .TX_DATA_STROBE(stb), .TX_RZ_FORMAT(rzf), .LINE_CODE_AMI(ami), .TX_POWER_DOWN(pdn),
        .CURRENT_LIMIT(clim), .TERMINATION_SELECT(term), .TERM_TRANSFORMERLESS(tless),
        .TERM_EXTERNAL(text), .LINE_TIP_OUT(), .LINE_TIP_OE(tipoe), .LINE_RING_OUT(),
        .LINE_RING_OE(ringoe), .MULTIFUNCTION_OUT_PIN(mf));
    framer_model u_framer (.run(run), .edge_rise(erise), .rz(rz), .pattern(pat),
        .clk_pin(fclk), .data_pin(fdat), .pos_pin(fpos), .neg_pin(fneg));
    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end
    function automatic logic [12:0] ld(input int c);
        return 13'((c * 64 + 4) * 4);
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [12:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic t_regs;
        for (int c = 0; c < 4; c++) begin
            apb(0, ld(c), 8'h00);
            chk(rd, 32'h0);
            apb(0, ld(c) + 13'h4, 8'h00);
            chk(rd, 32'h1);
        end
        chk(tipoe, 4'h0);
        apb(1, 13'h0018, 8'h55);
        apb(0, 13'h0018, 8'h00);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1, ld(0) + 13'h4, 8'hFF);
        apb(1, ld(1), 8'hFF);
        apb(0, ld(0) + 13'h4, 8'h00);
        chk(rd, 32'hFD);
        wt(2);
        chk({ami, pdn, tipoe}, 12'h120);
        apb(1, ld(1), 8'h00);
        apb(1, ld(0) + 13'h4, 8'h01);
    endtask
    task automatic t_line;
        apb(1, ld(0), 8'h40);
        wt(2);
        chk({tipoe[0], ringoe[0]}, 2'h3);
        apb(1, ld(0), 8'h48);
        wt(2);
        chk({tipoe[0], ringoe[0]}, 2'h2);
        apb(1, ld(0), 8'h60);
        wt(2);
        chk({pdn[0], tipoe[0]}, 2'h2);
        for (int c = 0; c < 8; c++) begin
            apb(1, ld(0), 8'(c));
            wt(2);
            chk({text[0], tless[0], term[2:0]}, {c == 7, c > 3 && c < 7, 3'(c)});
        end
    endtask
    task automatic t_link;
        int n;
        logic [7:0] p;
        logic [1:0] f;
        logic e;
        for (int m = 0; m < 6; m++) begin
            f = 2'(m % 3);
            e = m > 2;
            p = 8'hB4 ^ 8'(m * 37);
            apb(1, ld(0) + 13'h4, {3'h0, e, 2'h0, f});
            apb(1, ld(1) + 13'h4, {3'h0, e, 2'h2, f});
            erise <= e;
            rz <= f == 2'h2;
            pat <= p;
            wt(1);
            chk(rzf[0], f == 2'h2);
            run <= 1'b1;
            for (int i = 7; i >= 0; i--) begin
                n = 0;
                do begin
                    @(posedge clk);
                    n++;
                end while (stb[0] !== 1'b1 && n < 100);
                chk({pos_o[1:0], neg_o[0]}, {!p[i], p[i], f != 2'h0 && !p[i]});
                if (i == 0) run <= 1'b0;
            end
            // Let the framer end its frame before the next mode
            wt(20);
        end
    endtask
    task automatic t_mf;
        for (int f = 0; f < 3; f++) begin
            for (int c = 0; c < 16; c++) begin
                ind[3] <= c[3] ? 7'h7F : 7'h00;
                oc[3] <= c[3];
                apb(1, ld(3) + 13'h4, {c[2:0], 3'h0, 2'(f)});
                wt(4);
                chk(mf[3], c[3] && f != 1 && (c[2:0] < 5 || f == 2));
            end
        end
        oc[3] <= 1'b0;
    endtask
    task automatic t_irq_oc;
        apb(1, 13'h1FC4, 8'h01);
        apb(0, 13'h1FC0, 8'h00);
        oc[0] <= 1'b1;
        wt(6);
        chk(irq, 1'b1);
        apb(0, 13'h1FC0, 8'h00);
        chk(rd[0], 1'b1);
        oc[1] <= 1'b1;
        wt(6);
        chk(irq, 1'b0);
        oc <= 4'h0;
        apb(1, ld(0), 8'h50);
        oc[0] <= 1'b1;
        wt(8);
        chk({clim[0], tipoe[0]}, 2'h3);
        wt(OCH + 4);
        chk({clim[0], tipoe[0]}, 2'h0);
        apb(0, 13'h1FC0, 8'h00);
        chk(rd[5:4], 2'h1);
        oc[0] <= 1'b0;
        apb(1, ld(0), 8'h40);
        oc[0] <= 1'b1;
        wt(OCH * 3);
        chk({clim[0], tipoe[0]}, 2'h3);
        oc[0] <= 1'b0;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            close_out;
        end
    end
    initial begin
        rstn = 1'b0;
        {psel, pen, pwr, paddr, pwdata, oc, run, erise, rz, pat} = '0;
        ind = '0;
        {failures, n_checks, cyc} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_line;
        t_link;
        t_mf;
        t_irq_oc;
        close_out;
    end
endmodule
